//--- core/sti_ctrl.v
// standard, top level and peripheral interrupt arbitration with apb registers
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "sti_defines.vh"
module sti_ctrl #(
	parameter NSTD = 9
) (
	// clock, reset, enable
	input  wire        clk,
	input  wire        srst,
	input  wire        ce,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	// event sources
	input  wire [7:0]  can_evt,
	input  wire        serial_evt,
	input  wire        periph_evt,
	input  wire        wdg_eoc,
	input  wire        nmi_pin,
	// processor core
	input  wire        instr_wrote,
	input  wire        instr_done,
	input  wire        iret_done,
	input  wire        wfi_mode,
	output wire        irq_req,
	output reg         irq_ack,
	output reg         irq_abort,
	output reg         isr_start,
	output reg  [7:0]  irq_vector,
	output reg  [2:0]  irq_level,
	output wire        tl_active,
	output wire        dma_block
);
	localparam S_IDLE  = 4'b0001;
	localparam S_ACK   = 4'b0010;
	localparam S_HOLD  = 4'b0100;
	localparam S_ENTRY = 4'b1000;
	localparam SRC_STD = 2'd0;
	localparam SRC_PER = 2'd1;
	localparam SRC_TL  = 2'd2;

	reg  [NSTD-1:0] std_pend_r;
	reg  [NSTD-1:0] std_pend_nxt;
	reg  [NSTD-1:0] mask_r;
	reg  [NSTD-1:0] trig_r;
	reg  [NSTD-1:0] ovr_r;
	reg  [NSTD-1:0] ovr_nxt;
	reg  [7:0]      prio_lo_r;
	reg  [1:0]      prio_hi_r;
	reg  [2:0]      vect_hi_r;
	reg  [3:0]      chan_id_r;
	reg             gcen_r;
	reg             tlp_r;
	reg             tlp_nxt;
	reg             tle_r;
	reg             ien_r;
	reg             iam_r;
	reg  [2:0]      cpl_r;
	reg  [3:0]      ext_vector_ctrl_r;
	reg             unmask_r;
	reg  [6:0]      hold_r;
	reg             per_pend_r;
	reg             per_pend_nxt;
	reg             per_mask_r;
	reg  [2:0]      per_prio_r;
	reg  [6:0]      per_vec_r;
	reg             csr_push_r;
	reg             stack_rf_r;
	reg  [3:0]      state_r;
	reg  [2:0]      arb_cnt_r;
	reg  [4:0]      entry_cnt_r;
	reg  [1:0]      win_src_r;
	reg  [3:0]      win_id_r;
	reg             tl_act_r;
	reg  [3:0]      best_id;
	reg  [2:0]      best_pr;
	reg             best_ok;
	reg  [31:0]     rd_val;
	reg             rd_err;
	reg  [2:0]      pop_lvl;
	reg             pop_ok;
	wire [NSTD-1:0] std_evt;
	wire            nmi_evt;
	wire            wdg_evt;
	wire            per_evt;
	wire            tl_evt;
	wire            wr;
	wire            rd_setup;
	wire            std_ok;
	wire            per_ok;
	wire            tl_req;
	wire            arb_slot;
	wire [4:0]      entry_len;
	integer         k;

	function [2:0] std_prio;
		input [3:0] idx;
		input [7:0] lo;
		input [1:0] hi;
		begin
			if (idx == 4'h8)
				std_prio = {hi, 1'b0};
			else
				std_prio = {lo[{idx[2:1], 1'b1}], lo[{idx[2:1], 1'b0}], idx[0]};
		end
	endfunction

	// can units on E0..H1, serial on I0
	sti_edge #(.W(NSTD), .SYNC(0)) u_std_edge (
		.clk      (clk),
		.srst     (srst),
		.ce       (ce),
		.din      ({serial_evt, can_evt}),
		.rise_sel (trig_r),
		.evt      (std_evt)
	);

	// pin crosses in from outside, so it is synchronised first
	sti_edge #(.W(1), .SYNC(1)) u_nmi_edge (
		.clk      (clk),
		.srst     (srst),
		.ce       (ce),
		.din      (nmi_pin),
		.rise_sel (ext_vector_ctrl_r[`STI_EXT_VECTOR_CTRL_TOP_LEVEL_EDGE_SEL]),
		.evt      (nmi_evt)
	);

	sti_edge #(.W(1), .SYNC(0)) u_wdg_edge (
		.clk      (clk),
		.srst     (srst),
		.ce       (ce),
		.din      (wdg_eoc),
		.rise_sel (1'b1),
		.evt      (wdg_evt)
	);

	sti_edge #(.W(1), .SYNC(0)) u_per_edge (
		.clk      (clk),
		.srst     (srst),
		.ce       (ce),
		.din      (periph_evt),
		.rise_sel (1'b1),
		.evt      (per_evt)
	);

	assign tl_evt = ext_vector_ctrl_r[`STI_EXT_VECTOR_CTRL_TOP_LEVEL_SOURCE_SEL] ? nmi_evt : wdg_evt;

	assign pready   = psel & penable;
	assign wr       = ce & psel & penable & pwrite;
	assign rd_setup = ce & psel & ~penable;

	// strict compare keeps the lowest index on ties
	always @* begin
		best_id = 4'h0;
		best_pr = 3'h7;
		best_ok = 1'b0;
		for (k = 0; k < NSTD; k = k + 1) begin
			if (std_pend_r[k] && mask_r[k] &&
			    (!best_ok || std_prio(k[3:0], prio_lo_r, prio_hi_r) < best_pr)) begin
				best_id = k[3:0];
				best_pr = std_prio(k[3:0], prio_lo_r, prio_hi_r);
				best_ok = 1'b1;
			end
		end
	end

	// level 7 never beats any current level
	assign std_ok = best_ok & ien_r & (best_pr < cpl_r);
	assign per_ok = per_pend_r & per_mask_r & ien_r & (per_prio_r < cpl_r);
	assign tl_req = tlp_r & ((tle_r & ien_r) | unmask_r);

	assign arb_slot = (arb_cnt_r == `STI_ARB_CYCLES - 3'd1);

	// response is slot wait plus entry
	assign entry_len = `STI_ENTRY_BASE
	                 + (stack_rf_r ? `STI_ENTRY_STACK : 5'd0)
	                 + (csr_push_r ? `STI_ENTRY_CSR : 5'd0)
	                 + (wfi_mode ? `STI_ENTRY_WAKE : 5'd0);

	// hold stack pops the most urgent saved level
	always @* begin
		pop_lvl = 3'h7;
		pop_ok  = 1'b0;
		for (k = 6; k >= 0; k = k - 1) begin
			if (hold_r[k]) begin
				pop_lvl = k[2:0];
				pop_ok  = 1'b1;
			end
		end
	end

	// hardware sets are applied last so an event beats a clear in the same cycle
	always @* begin
		std_pend_nxt = std_pend_r;
		ovr_nxt      = ovr_r;
		tlp_nxt      = tlp_r;
		per_pend_nxt = per_pend_r;
		if (wr) begin
			case (paddr)
				`STI_OFF_PEND_LO:  std_pend_nxt[7:0] = pwdata[7:0];
				`STI_OFF_PEND_HI:  std_pend_nxt[8]   = pwdata[0];
				`STI_OFF_OVR_LO:   ovr_nxt[7:0]      = ovr_r[7:0] & ~pwdata[7:0];
				`STI_OFF_OVR_HI:   ovr_nxt[8]        = ovr_r[8] & ~pwdata[0];
				`STI_OFF_CENTRAL_IRQ_CTRL:     tlp_nxt           = pwdata[`STI_CENTRAL_IRQ_CTRL_TLP];
				`STI_OFF_PER_CTRL: per_pend_nxt      = pwdata[`STI_PER_PEND];
				default:           tlp_nxt           = tlp_r;
			endcase
		end
		if (state_r == S_ACK) begin
			case (win_src_r)
				SRC_STD: std_pend_nxt[win_id_r] = 1'b0;
				SRC_PER: per_pend_nxt           = 1'b0;
				default: tlp_nxt                = 1'b0;
			endcase
		end
		ovr_nxt = ovr_nxt | (std_evt & std_pend_r);
		std_pend_nxt = std_pend_nxt | std_evt;
		tlp_nxt      = tlp_nxt | tl_evt;
		per_pend_nxt = per_pend_nxt | per_evt;
	end

	always @* begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		case (paddr)
			`STI_OFF_PEND_LO:  rd_val[7:0] = std_pend_r[7:0];
			`STI_OFF_PEND_HI:  rd_val[0]   = std_pend_r[8];
			`STI_OFF_MASK_LO:  rd_val[7:0] = mask_r[7:0];
			`STI_OFF_MASK_HI:  rd_val[0]   = mask_r[8];
			`STI_OFF_TRIG_LO:  rd_val[7:0] = trig_r[7:0];
			`STI_OFF_TRIG_HI:  rd_val[0]   = trig_r[8];
			`STI_OFF_PRIO_LO:  rd_val[7:0] = prio_lo_r;
			`STI_OFF_PRIO_HI:  rd_val[1:0] = prio_hi_r;
			`STI_OFF_VECT:     rd_val[7:0] = {vect_hi_r, chan_id_r, 1'b0};
			`STI_OFF_OVR_LO:   rd_val[7:0] = ovr_r[7:0];
			`STI_OFF_OVR_HI:   rd_val[0]   = ovr_r[8];
			`STI_OFF_CENTRAL_IRQ_CTRL:     rd_val[7:0] = {gcen_r, tlp_r, tle_r, ien_r, iam_r, cpl_r};
			`STI_OFF_EXT_VECTOR_CTRL:     rd_val[3:0] = ext_vector_ctrl_r;
			`STI_OFF_NESTED_HOLD_LEVELS:     rd_val[7:0] = {unmask_r, hold_r};
			`STI_OFF_PER_CTRL: rd_val[4:0] = {per_prio_r, per_mask_r, per_pend_r};
			`STI_OFF_PER_VECT: rd_val[7:0] = {per_vec_r, 1'b0};
			`STI_OFF_CORE_CFG: rd_val[1:0] = {stack_rf_r, csr_push_r};
			default:           rd_err      = 1'b1;
		endcase
	end

	// read data is captured in the setup cycle so it leaves a flop
	always @(posedge clk) begin
		if (srst) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (rd_setup) begin
			prdata  <= pwrite ? 32'h0000_0000 : rd_val;
			pslverr <= rd_err;
		end
	end

	// software registers
	always @(posedge clk) begin
		if (srst) begin
			mask_r     <= {NSTD{1'b0}};
			trig_r     <= {NSTD{1'b0}};
			prio_lo_r  <= `STI_PRIO_RST;
			prio_hi_r  <= 2'h3;
			vect_hi_r  <= 3'h0;
			gcen_r     <= 1'b1;
			tle_r      <= 1'b0;
			iam_r      <= 1'b0;
			ext_vector_ctrl_r     <= `STI_EXT_VECTOR_CTRL_RST;
			per_mask_r <= 1'b0;
			per_prio_r <= 3'h7;
			per_vec_r  <= 7'h00;
			csr_push_r <= 1'b0;
			stack_rf_r <= 1'b0;
		end else if (wr) begin
			case (paddr)
				`STI_OFF_MASK_LO:  mask_r[7:0] <= pwdata[7:0];
				`STI_OFF_MASK_HI:  mask_r[8]   <= pwdata[0];
				`STI_OFF_TRIG_LO:  trig_r[7:0] <= pwdata[7:0];
				`STI_OFF_TRIG_HI:  trig_r[8]   <= pwdata[0];
				`STI_OFF_PRIO_LO:  prio_lo_r   <= pwdata[7:0];
				`STI_OFF_PRIO_HI:  prio_hi_r   <= pwdata[1:0];
				`STI_OFF_VECT:     vect_hi_r   <= pwdata[7:5];
				`STI_OFF_CENTRAL_IRQ_CTRL: begin
					gcen_r <= pwdata[`STI_CENTRAL_IRQ_CTRL_GCEN];
					tle_r  <= pwdata[`STI_CENTRAL_IRQ_CTRL_TLE];
					iam_r  <= pwdata[`STI_CENTRAL_IRQ_CTRL_IAM];
				end
				`STI_OFF_EXT_VECTOR_CTRL:     ext_vector_ctrl_r      <= pwdata[3:0];
				`STI_OFF_PER_CTRL: begin
					per_mask_r <= pwdata[`STI_PER_MASK];
					per_prio_r <= pwdata[`STI_PER_PRIO_LSB+2:`STI_PER_PRIO_LSB];
				end
				`STI_OFF_PER_VECT: per_vec_r   <= pwdata[7:1];
				`STI_OFF_CORE_CFG: begin
					csr_push_r <= pwdata[`STI_CFG_CSR_PUSH];
					stack_rf_r <= pwdata[`STI_CFG_STACK_RF];
				end
				default:           vect_hi_r   <= vect_hi_r;
			endcase
		end
	end

	// flags, vector tracking and the arbitration sequencer
	always @(posedge clk) begin
		if (srst) begin
			std_pend_r  <= {NSTD{1'b0}};
			ovr_r       <= {NSTD{1'b0}};
			tlp_r       <= 1'b0;
			per_pend_r  <= 1'b0;
			chan_id_r   <= 4'h0;
			ien_r       <= 1'b0;
			cpl_r       <= 3'h7;
			unmask_r    <= 1'b0;
			hold_r      <= 7'h00;
			state_r     <= S_IDLE;
			arb_cnt_r   <= 3'h0;
			entry_cnt_r <= 5'h00;
			win_src_r   <= SRC_STD;
			win_id_r    <= 4'h0;
			tl_act_r    <= 1'b0;
			irq_ack     <= 1'b0;
			irq_abort   <= 1'b0;
			isr_start   <= 1'b0;
			irq_vector  <= 8'h00;
			irq_level   <= 3'h7;
		end else if (ce) begin
			std_pend_r <= std_pend_nxt;
			ovr_r      <= ovr_nxt;
			tlp_r      <= tlp_nxt;
			per_pend_r <= per_pend_nxt;
			irq_ack    <= 1'b0;
			irq_abort  <= 1'b0;
			isr_start  <= 1'b0;
			arb_cnt_r  <= arb_slot ? 3'h0 : arb_cnt_r + 3'h1;
			// vector follows the best pending channel
			if (best_ok)
				chan_id_r <= best_id;
			if (wr && paddr == `STI_OFF_CENTRAL_IRQ_CTRL) begin
				ien_r <= pwdata[`STI_CENTRAL_IRQ_CTRL_IEN];
				cpl_r <= pwdata[2:0];
			end
			if (wr && paddr == `STI_OFF_NESTED_HOLD_LEVELS) begin
				hold_r <= pwdata[6:0];
				if (pwdata[`STI_NESTED_HOLD_LEVELS_TOP_LEVEL_UNMASKABLE])
					unmask_r <= 1'b1;
			end
			// return from top level touches nothing else
			if (iret_done && tl_act_r) begin
				tl_act_r <= 1'b0;
			end else if (iret_done) begin
				ien_r <= 1'b1;
				if (iam_r) begin
					cpl_r <= pop_lvl;
					if (pop_ok)
						hold_r[pop_lvl] <= 1'b0;
				end
			end
			case (state_r)
				S_IDLE: begin
					// nothing is arbitrated during the top level routine
					if (arb_slot && !tl_act_r && (tl_req || std_ok || per_ok)) begin
						state_r <= S_ACK;
						irq_ack <= 1'b1;
						if (tl_req) begin
							win_src_r  <= SRC_TL;
							irq_vector <= `STI_TL_VECTOR;
							irq_level  <= 3'h0;
						end else if (std_ok && (!per_ok || best_pr <= per_prio_r)) begin
							win_src_r  <= SRC_STD;
							win_id_r   <= best_id;
							irq_vector <= {vect_hi_r, best_id, 1'b0};
							irq_level  <= best_pr;
						end else begin
							win_src_r  <= SRC_PER;
							irq_vector <= {per_vec_r, 1'b0};
							irq_level  <= per_prio_r;
						end
					end
				end
				S_ACK: begin
					entry_cnt_r <= entry_len;
					if (win_src_r == SRC_TL) begin
						// block starts the cycle after the top level acknowledge
						tl_act_r <= 1'b1;
					end else begin
						ien_r <= 1'b0;
						if (iam_r) begin
							if (cpl_r != 3'h7)
								hold_r[cpl_r] <= 1'b1;
							cpl_r <= irq_level;
						end
					end
					// abort only if nothing was written yet
					if (!instr_wrote) begin
						irq_abort <= 1'b1;
						state_r   <= S_ENTRY;
					end else begin
						state_r   <= S_HOLD;
					end
				end
				S_HOLD: begin
					if (instr_done)
						state_r <= S_ENTRY;
				end
				S_ENTRY: begin
					if (entry_cnt_r <= 5'd1) begin
						isr_start <= 1'b1;
						state_r   <= S_IDLE;
					end else begin
						entry_cnt_r <= entry_cnt_r - 5'd1;
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	assign irq_req   = state_r[1] | state_r[2];
	assign tl_active = tl_act_r;
	assign dma_block = tl_act_r;
endmodule // sti_ctrl

//--- core/sti_defines.vh
// register map, field positions, reset values and timing counts of the interrupt block
`ifndef STI_DEFINES_VH
`define STI_DEFINES_VH
// Notes on behaviour
// - two CAN units feed E0..H1, serial unit feeds I0, I1 never requests
// - standard pending set by selected edge, cleared on acknowledge
// - standard mask bit cleared blocks the channel request, set passes it
// - priority upper two bits from software, lsb 0 even, 1 odd channels
// - shared vector register bits 1..4 show best pending channel
// - equal priorities served in daisy order, E0 first, I0 last
// - overrun flag set when a new event finds pending still set
// - source select (reset 1) picks pin or watchdog, edge select rise/fall
// - selected top level event sets the top level pending bit
// - maskable top level request needs pending, enable and global enable
// - unmaskable bit set by software, reset only clears, ignores global enable
// - top level routine blocks all interrupts and DMA, even top level
// - top level entry and return leave enable, level and hold stack alone
// - peripheral request needs mask, pending and global enable all 1
// - priority 0 highest, 7 lowest, level 7 never acknowledged
// - arbitration every 5 cycles, plus one cycle for acknowledge
// - abort instruction if nothing written, else wait for its end
// - response 26..55 cycles standard, 22..51 top level
// - entry 18 cycles, +2 stack in file, +2 code segment push, +1 wake
// - non top level entry clears global enable, return sets it

// byte offsets on the register bus
`define STI_OFF_PEND_LO   8'h00
`define STI_OFF_PEND_HI   8'h04
`define STI_OFF_MASK_LO   8'h08
`define STI_OFF_MASK_HI   8'h0C
`define STI_OFF_TRIG_LO   8'h10
`define STI_OFF_TRIG_HI   8'h14
`define STI_OFF_PRIO_LO   8'h18
`define STI_OFF_PRIO_HI   8'h1C
`define STI_OFF_VECT      8'h20
`define STI_OFF_OVR_LO    8'h24
`define STI_OFF_OVR_HI    8'h28
`define STI_OFF_CENTRAL_IRQ_CTRL      8'h2C
`define STI_OFF_EXT_VECTOR_CTRL      8'h30
`define STI_OFF_NESTED_HOLD_LEVELS      8'h34
`define STI_OFF_PER_CTRL  8'h38
`define STI_OFF_PER_VECT  8'h3C
`define STI_OFF_CORE_CFG  8'h40

// central control fields
`define STI_CENTRAL_IRQ_CTRL_GCEN     7
`define STI_CENTRAL_IRQ_CTRL_TLP      6
`define STI_CENTRAL_IRQ_CTRL_TLE      5
`define STI_CENTRAL_IRQ_CTRL_IEN      4
`define STI_CENTRAL_IRQ_CTRL_IAM      3
`define STI_CENTRAL_IRQ_CTRL_RST      8'h87
// vector control fields
`define STI_EXT_VECTOR_CTRL_TOP_LEVEL_EDGE_SEL    3
`define STI_EXT_VECTOR_CTRL_TOP_LEVEL_SOURCE_SEL     2
`define STI_EXT_VECTOR_CTRL_IA0S     1
`define STI_EXT_VECTOR_CTRL_EWEN     0
`define STI_EXT_VECTOR_CTRL_RST      4'h6
`define STI_NESTED_HOLD_LEVELS_TOP_LEVEL_UNMASKABLE     7
`define STI_PRIO_RST      8'hFF
// peripheral control fields
`define STI_PER_PEND      0
`define STI_PER_MASK      1
`define STI_PER_PRIO_LSB  2
`define STI_CFG_CSR_PUSH  0
`define STI_CFG_STACK_RF  1

// timing in cpu clock cycles
`define STI_ARB_CYCLES    3'd5
`define STI_ENTRY_BASE    5'd18
`define STI_ENTRY_STACK   5'd2
`define STI_ENTRY_CSR     5'd2
`define STI_ENTRY_WAKE    5'd1
`define STI_TL_VECTOR     8'h00
`endif

//--- core/sti_edge.v
// edge detector with selectable polarity and optional two-flop synchroniser
`timescale 1ns/1ns
module sti_edge #(
	parameter W    = 1,
	parameter SYNC = 0
) (
	// clock and control
	input  wire         clk,
	input  wire         srst,
	input  wire         ce,
	// sources, 1 in rise_sel picks rising edge
	input  wire [W-1:0] din,
	input  wire [W-1:0] rise_sel,
	output wire [W-1:0] evt
);
	reg  [W-1:0] prev_r;
	wire [W-1:0] cur;

	generate
		if (SYNC != 0) begin : g_sync
			reg [W-1:0] meta_r;
			reg [W-1:0] lvl_r;
			always @(posedge clk) begin
				if (srst) begin
					meta_r <= {W{1'b0}};
					lvl_r  <= {W{1'b0}};
				end else if (ce) begin
					meta_r <= din;
					lvl_r  <= meta_r;
				end
			end
			assign cur = lvl_r;
		end else begin : g_direct
			assign cur = din;
		end
	endgenerate

	always @(posedge clk) begin
		if (srst)
			prev_r <= {W{1'b0}};
		else if (ce)
			prev_r <= cur;
	end

	assign evt = (cur & ~prev_r & rise_sel) | (~cur & prev_r & ~rise_sel);
endmodule // sti_edge

//--- verif/sti_core_model.sv
// behavioural model of the processor core side of the interrupt block
`timescale 1ns/1ns
module sti_core_model #(
	parameter ISR_LEN = 60
) (
	// clock and reset
	input  wire        clk,
	input  wire        srst,
	// from the interrupt block
	input  wire        irq_ack,
	input  wire        isr_start,
	// bench settings
	input  wire        wrote_cfg,
	input  wire        wfi_cfg,
	// to the interrupt block
	output wire        instr_wrote,
	output logic       instr_done,
	output logic       iret_done,
	output wire        wfi_mode
);
	logic [7:0] run_r;
	logic [2:0] done_r;

	assign wfi_mode = wfi_cfg;
	assign instr_wrote = wrote_cfg;

	always @(posedge clk) begin
		if (srst) begin
			run_r <= 8'h00;
			done_r <= 3'h0;
			instr_done <= 1'b0;
			iret_done <= 1'b0;
		end else begin
			if (irq_ack && wrote_cfg)
				done_r <= 3'h3;
			else if (done_r != 3'h0)
				done_r <= done_r - 3'h1;
			instr_done <= (done_r == 3'h1);
			// routine length before return
			if (isr_start)
				run_r <= 8'(ISR_LEN);
			else if (run_r != 8'h00)
				run_r <= run_r - 8'h01;
			iret_done <= (run_r == 8'h01);
		end
	end
endmodule // sti_core_model

//--- verif/sti_ctrl_checker.sv
// port assertions for the interrupt block
`timescale 1ns/1ns
module sti_ctrl_checker (
	// clock and reset
	input wire       clk,
	input wire       srst,
	// bus handshake
	input wire       psel,
	input wire       penable,
	input wire       pready,
	// core side
	input wire       instr_wrote,
	input wire       irq_req,
	input wire       irq_ack,
	input wire       irq_abort,
	input wire       isr_start,
	input wire [7:0] irq_vector,
	input wire [2:0] irq_level,
	input wire       tl_active,
	input wire       dma_block
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_ready_zero_wait: assert property (pready == (psel && penable))
		else $error("pready does not follow access phase");
	a_ack_slot: assert property (irq_ack |=> !irq_ack [*4])
		else $error("acknowledges closer than one slot");
	a_ack_req: assert property (irq_ack |-> irq_req)
		else $error("acknowledge without request");
	a_abort_cause: assert property (irq_abort |-> $past(irq_ack) && !$past(instr_wrote))
		else $error("abort without clean acknowledge");
	a_abort_now: assert property (irq_ack && !instr_wrote |=> irq_abort)
		else $error("abort missing after acknowledge");
	a_entry_len: assert property (irq_abort |-> ##[18:25] isr_start)
		else $error("entry cycle length wrong");
	a_level_seven: assert property (irq_ack |-> irq_level != 3'h7)
		else $error("level seven acknowledged");
	a_top_block: assert property ($past(tl_active) && tl_active |-> !irq_ack)
		else $error("acknowledge inside top level routine");
	a_dma_top: assert property (dma_block == tl_active)
		else $error("dma block differs from top level state");
	a_vector_hold: assert property ($changed(irq_vector) || $changed(irq_level) |-> irq_ack)
		else $error("vector or level changed without acknowledge");
	a_reset_clear: assert property ($past(srst) |-> !irq_req && !tl_active && irq_level == 3'h7)
		else $error("state not cleared by reset");

	c_abort: cover property (irq_abort);
	c_hold: cover property (irq_ack && instr_wrote);
	c_top: cover property ($rose(tl_active));
endmodule // sti_ctrl_checker

bind sti_ctrl sti_ctrl_checker u_chk (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
	.pready(pready), .instr_wrote(instr_wrote), .irq_req(irq_req), .irq_ack(irq_ack),
	.irq_abort(irq_abort), .isr_start(isr_start), .irq_vector(irq_vector),
	.irq_level(irq_level), .tl_active(tl_active), .dma_block(dma_block));

//--- verif/tb_standard_and_top_level_interrupts.sv
// self-checking bench for the interrupt block
`timescale 1ns/1ns
`include "sti_defines.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module tb_standard_and_top_level_interrupts;
	typedef struct {logic w; logic [7:0] a; logic [7:0] v; logic err;} sti_row_t;
	logic        clk, srst, ce, psel, penable, pwrite, pready, pslverr, nmi_pin, rerr, got;
	logic        instr_wrote, instr_done, iret_done, wfi_mode, wrote_cfg, wfi_cfg;
	logic        irq_req, irq_ack, irq_abort, isr_start, tl_active, dma_block;
	logic [7:0]  paddr, irq_vector;
	logic [10:0] src;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  irq_level;
	int          errors, samples_checked, k;
	sti_row_t    rows [10] = '{'{0, `STI_OFF_CENTRAL_IRQ_CTRL, 8'h87, 0}, '{0, `STI_OFF_EXT_VECTOR_CTRL, 8'h06, 0},
		'{0, `STI_OFF_PRIO_LO, 8'hFF, 0}, '{0, `STI_OFF_PRIO_HI, 8'h03, 0},
		'{0, `STI_OFF_PEND_LO, 8'h00, 0}, '{0, `STI_OFF_NESTED_HOLD_LEVELS, 8'h00, 0},
		'{0, `STI_OFF_PER_CTRL, 8'h1C, 0}, '{1, `STI_OFF_MASK_LO, 8'hA5, 0},
		'{0, `STI_OFF_MASK_LO, 8'hA5, 0}, '{0, 8'h80, 8'h00, 1}};

	sti_ctrl DUT (.clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .can_evt(src[7:0]), .serial_evt(src[8]), .periph_evt(src[9]),
		.wdg_eoc(src[10]), .nmi_pin(nmi_pin), .instr_wrote(instr_wrote),
		.instr_done(instr_done), .iret_done(iret_done), .wfi_mode(wfi_mode),
		.irq_req(irq_req), .irq_ack(irq_ack), .irq_abort(irq_abort), .isr_start(isr_start),
		.irq_vector(irq_vector), .irq_level(irq_level), .tl_active(tl_active),
		.dma_block(dma_block));
	sti_core_model #(.ISR_LEN(60)) u_core (.clk(clk), .srst(srst), .irq_ack(irq_ack),
		.isr_start(isr_start), .wrote_cfg(wrote_cfg), .wfi_cfg(wfi_cfg),
		.instr_wrote(instr_wrote), .instr_done(instr_done), .iret_done(iret_done),
		.wfi_mode(wfi_mode));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task summarize;
		if (errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			errors++;
			summarize();
		end
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// sel 0 acknowledge, 1 routine start, 2 return
	task wait_for(input int sel, input int n);
		got = 1'b0;
		for (int i = 0; i < n && got !== 1'b1; i++) begin
			@(posedge clk);
			got = (sel == 0) ? irq_ack : (sel == 1) ? isr_start : iret_done;
		end
	endtask

	task need(input int sel);
		wait_for(sel, 200);
		if (got !== 1'b1) begin
			errors++;
			summarize();
		end
	endtask

	task pulse(input int b);
		src[b] <= 1'b1;
		repeat (3) @(posedge clk);
		src[b] <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	initial begin
		{srst, ce, nmi_pin} = 3'h7;
		{psel, penable, pwrite, paddr, pwdata, src, wrote_cfg, wfi_cfg} = '0;
		errors = 0;
		samples_checked = 0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, {24'h0, rows[i].v});
			`CHK({rerr, rd}, {rows[i].err, rows[i].w ? 32'h0 : {24'h0, rows[i].v}})
		end
		apb(1'b1, `STI_OFF_TRIG_LO, 32'hFF);
		apb(1'b1, `STI_OFF_TRIG_HI, 32'h01);
		apb(1'b1, `STI_OFF_MASK_LO, 32'hFF);
		apb(1'b1, `STI_OFF_MASK_HI, 32'h01);
		pulse(4);
		pulse(2);
		apb(1'b0, `STI_OFF_PEND_LO, 32'h0);
		`CHK(rd, 32'h14)
		apb(1'b0, `STI_OFF_VECT, 32'h0);
		`CHK(rd[4:1], 4'h2)
		apb(1'b1, `STI_OFF_PRIO_LO, 32'hCF);
		apb(1'b0, `STI_OFF_VECT, 32'h0);
		`CHK(rd[4:1], 4'h4)
		apb(1'b1, `STI_OFF_CENTRAL_IRQ_CTRL, 32'h97);
		need(0);
		`CHK(irq_level, 3'h0)
		`CHK(irq_vector, 8'h08)
		need(1);
		apb(1'b0, `STI_OFF_PEND_LO, 32'h0);
		`CHK(rd, 32'h04)
		apb(1'b0, `STI_OFF_CENTRAL_IRQ_CTRL, 32'h0);
		`CHK(rd[4], 1'b0)
		need(2);
		need(0);
		`CHK(irq_level, 3'h6)
		need(2);
		apb(1'b1, `STI_OFF_CENTRAL_IRQ_CTRL, 32'h87);
		pulse(8);
		pulse(8);
		apb(1'b0, `STI_OFF_OVR_HI, 32'h0);
		`CHK(rd[0], 1'b1)
		apb(1'b0, `STI_OFF_PEND_HI, 32'h0);
		`CHK(rd, 32'h01)
		apb(1'b1, `STI_OFF_MASK_HI, 32'h00);
		apb(1'b1, `STI_OFF_CENTRAL_IRQ_CTRL, 32'h97);
		wait_for(0, 30);
		`CHK(got, 1'b0)
		// falling edge on the pin with top level disabled
		nmi_pin <= 1'b0;
		wait_for(0, 20);
		`CHK(got, 1'b0)
		apb(1'b0, `STI_OFF_CENTRAL_IRQ_CTRL, 32'h0);
		`CHK(rd[6], 1'b1)
		apb(1'b1, `STI_OFF_CENTRAL_IRQ_CTRL, 32'hF7);
		need(0);
		`CHK(irq_level, 3'h0)
		// wait out the entry so only the top level block can hold off I0
		need(1);
		apb(1'b1, `STI_OFF_MASK_HI, 32'h01);
		wait_for(0, 20);
		`CHK(got, 1'b0)
		`CHK(tl_active, 1'b1)
		apb(1'b0, `STI_OFF_CENTRAL_IRQ_CTRL, 32'h0);
		`CHK(rd[4:0], 5'h17)
		need(2);
		need(0);
		`CHK(irq_level, 3'h6)
		need(2);
		apb(1'b1, `STI_OFF_NESTED_HOLD_LEVELS, 32'h80);
		apb(1'b1, `STI_OFF_NESTED_HOLD_LEVELS, 32'h00);
		apb(1'b0, `STI_OFF_NESTED_HOLD_LEVELS, 32'h0);
		`CHK(rd[7], 1'b1)
		apb(1'b1, `STI_OFF_EXT_VECTOR_CTRL, 32'h02);
		apb(1'b1, `STI_OFF_CENTRAL_IRQ_CTRL, 32'h87);
		src[10] <= 1'b1;
		need(0);
		src[10] <= 1'b0;
		`CHK(irq_level, 3'h0)
		need(2);
		apb(1'b1, `STI_OFF_CENTRAL_IRQ_CTRL, 32'h97);
		apb(1'b1, `STI_OFF_PER_CTRL, 32'h1E);
		wrote_cfg <= 1'b1;
		wfi_cfg <= 1'b1;
		src[9] <= 1'b1;
		wait_for(0, 20);
		`CHK(got, 1'b0)
		src[9] <= 1'b0;
		apb(1'b1, `STI_OFF_PER_CTRL, 32'h0F);
		need(0);
		`CHK(irq_level, 3'h3)
		need(1);
		need(2);
		// nested mode saves and restores the level, longest entry
		wrote_cfg <= 1'b0;
		apb(1'b1, `STI_OFF_CORE_CFG, 32'h03);
		apb(1'b1, `STI_OFF_CENTRAL_IRQ_CTRL, 32'h9E);
		pulse(4);
		need(1);
		apb(1'b0, `STI_OFF_CENTRAL_IRQ_CTRL, 32'h0);
		`CHK(rd[4:0], 5'h08)
		apb(1'b0, `STI_OFF_NESTED_HOLD_LEVELS, 32'h0);
		`CHK(rd[6:0], 7'h40)
		need(2);
		apb(1'b0, `STI_OFF_CENTRAL_IRQ_CTRL, 32'h0);
		`CHK(rd[4:0], 5'h1E)
		apb(1'b0, `STI_OFF_NESTED_HOLD_LEVELS, 32'h0);
		`CHK(rd[6:0], 7'h00)
		// mid-run reset is the only way to drop the set-only bit
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		apb(1'b0, `STI_OFF_NESTED_HOLD_LEVELS, 32'h0);
		`CHK(rd[7], 1'b0)
		summarize();
	end
endmodule // tb_standard_and_top_level_interrupts
